/* core/clock_source_startup_select.sv */
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Function
// - select code 1001 runs the low-frequency 32.768 kHz crystal oscillator.
// - crystal start-up 1K/1K/32K cycles, reset delay 4.1/65/65 ms; code 11 reserved.
// - crystal mode with option fuse programmed connects 36 pF on both pins.
// - codes 0101 to 1000 pick external RC in four frequency bands.
// - external RC: 18 cycles, delay none/4.1/65 ms; code 11 gives 6, 4.1 ms.
// - codes 0001 to 0100 pick internal RC 1/2/4/8 MHz; default 0001.
// - internal RC: 6 cycles, delay none/4.1/65 ms; default 10; 11 reserved.
// - during reset the calibration byte is copied into the trim register.
// - only the 1 MHz byte loads itself; software loads other trims.
// - trim zero is slowest, larger is faster, FF is fastest.
// - writing the 8-bit trim register retrims at once; all bits read/write.
// - the watchdog oscillator times the reset delay even on internal RC.
// - external RC with option fuse programmed adds 36 pF on crystal input.
// - trim spans 50-100% at 00, 75-150% at 7F, 100-200% at FF.
// - a fuse reading one is unprogrammed, zero is programmed.
// - reset delays count 4096 or 65536 watchdog oscillator cycles.
module clock_source_startup_select
    import clk_src_pkg::*;
#(
    parameter int LFXT_LONG_CK = CK_32K,
    parameter int WDT_LONG = WDT_64K,
    parameter int WDT_SHORT = WDT_4K
) (
    input wire logic clk_sys_in, // system clock
    input wire logic rst_in, // async reset, high
    input wire clk_src_pkg::fuse_s fuse_in, // configuration fuse pins
    input wire logic [7:0] calib_byte_in, // signature row high byte
    input wire logic wdt_osc_in, // watchdog oscillator
    input wire logic sleep_in, // power-down request from core
    input wire logic wake_in, // wake-up pin
    input wire clk_src_pkg::reg_req_s reg_in, // register port request
    output logic [7:0] reg_rdata_out, // read data, cycle after strobe
    output logic core_clk_en_out, // clock gate to core
    output clk_src_pkg::osc_ctl_s osc_ctl_out, // oscillator controls
    output logic [7:0] trim_value_out, // oscillator trim
    output logic fuse_reserved_out, // reserved start-up code seen
    output logic pdown_out // in power-down
);
    import clk_src_pkg::*;

    state_s s_q;
    state_s s_d;
    logic ck_load;
    logic [CNT_W-1:0] ck_val;
    logic ck_done;
    logic wdt_load;
    logic [CNT_W-1:0] wdt_val;
    logic wdt_done;
    logic wdt_tick;
    logic wake_sync;
    logic capture;
    logic trim_wr;
    src_e new_src;
    logic [CNT_W-1:0] reset_ticks;
    logic new_rsv;

    function automatic src_e decode_src(input logic [3:0] sel);
        src_e r;
        r = SRC_OTHER;
        if (sel == SEL_LFXT) begin
            r = SRC_LFXT;
        end
        if (sel >= SEL_ERC_LO && sel <= SEL_ERC_HI) begin
            r = SRC_ERC;
        end
        if (sel >= SEL_IRC_LO && sel <= SEL_IRC_HI) begin
            r = SRC_IRC;
        end
        return r;
    endfunction : decode_src

    // start-up length in system clock cycles
    function automatic int startup_ck(input src_e src, input logic [1:0] stup);
        int n;
        n = CK_6;
        case (src)
            // crystal start-up, reserved code takes the longest
            SRC_LFXT: n = (stup == STUP_00 || stup == STUP_01) ? CK_1K : LFXT_LONG_CK;
            SRC_ERC: n = (stup == STUP_11) ? CK_6 : CK_18;
            SRC_IRC: n = CK_6;
            default: n = CK_6;
        endcase
        return n;
    endfunction : startup_ck

    // extra delay after reset in watchdog ticks, zero for none
    function automatic int reset_dly(input src_e src, input logic [1:0] stup);
        int n;
        n = WDT_LONG;
        case (src)
            SRC_LFXT: n = (stup == STUP_00) ? WDT_SHORT : WDT_LONG;
            SRC_ERC: begin
                case (stup)
                    STUP_00: n = 0;
                    STUP_10: n = WDT_LONG;
                    default: n = WDT_SHORT;
                endcase
            end
            // internal RC reset delay, reserved code takes the longest
            SRC_IRC: begin
                case (stup)
                    STUP_00: n = 0;
                    STUP_01: n = WDT_SHORT;
                    default: n = WDT_LONG;
                endcase
            end
            default: n = WDT_LONG;
        endcase
        return n;
    endfunction : reset_dly

    assign new_src = decode_src(s_q.fuse_s2.src_sel);
    assign new_rsv = (new_src == SRC_LFXT || new_src == SRC_IRC) && s_q.fuse_s2.stup == STUP_11;
    assign capture = (s_q.ph == PH_CAPTURE) && (s_q.cap_cnt == 2'(CAP_WAIT));
    assign wake_sync = s_q.wake_sy[1];
    // the watchdog oscillator edge paces the reset delay
    assign wdt_tick = s_q.wdt_sy[1] & ~s_q.wdt_sy[2];
    assign trim_wr = reg_in.wr && reg_in.addr == REG_TRIM && !capture;
    assign reset_ticks = CNT_W'(reset_dly(s_q.src, s_q.fuse.stup));

    always_comb begin
        s_d = s_q;
        ck_load = 1'b0;
        ck_val = '0;
        wdt_load = 1'b0;
        wdt_val = reset_ticks;
        // two-stage synchronisers for pins
        s_d.fuse_m = fuse_in;
        s_d.fuse_s2 = s_q.fuse_m;
        s_d.cal_m = calib_byte_in;
        s_d.cal_s2 = s_q.cal_m;
        s_d.wdt_sy = {s_q.wdt_sy[1:0], wdt_osc_in};
        s_d.wake_sy = {s_q.wake_sy[0], wake_in};
        case (s_q.ph)
            PH_CAPTURE: begin
                s_d.cap_cnt = s_q.cap_cnt + 2'h1;
                if (capture) begin
                    // fuses latched once, after the synchroniser settles
                    s_d.fuse = s_q.fuse_s2;
                    s_d.src = new_src;
                    s_d.rsv = new_rsv;
                    // calibration byte loaded while the core is still held
                    // only the 1 MHz byte is loaded by hardware
                    s_d.trim = s_q.cal_s2;
                    ck_load = 1'b1;
                    ck_val = CNT_W'(startup_ck(new_src, s_q.fuse_s2.stup) - 1);
                    s_d.ph = PH_STARTUP;
                end
            end
            PH_STARTUP: begin
                if (ck_done) begin
                    // reset delay follows the start-up count
                    if (s_q.after_rst && reset_ticks != '0) begin
                        // load 4096 or 65536 watchdog cycles
                        wdt_load = 1'b1;
                        s_d.ph = PH_RST_DLY;
                    end else begin
                        s_d.ph = PH_RUN;
                    end
                    s_d.after_rst = 1'b0;
                end
            end
            PH_RST_DLY: begin
                if (wdt_done) begin
                    s_d.ph = PH_RUN;
                end
            end
            PH_RUN: begin
                if (sleep_in) begin
                    s_d.ph = PH_PDOWN;
                end
            end
            PH_PDOWN: begin
                if (wake_sync) begin
                    // wake-up repeats only the start-up count
                    ck_load = 1'b1;
                    ck_val = CNT_W'(startup_ck(s_q.src, s_q.fuse.stup) - 1);
                    s_d.ph = PH_STARTUP;
                end
            end
            default: begin
                s_d.ph = PH_CAPTURE;
            end
        endcase
        if (trim_wr) begin
            s_d.trim = reg_in.wdata;
        end
        // read data stands for one cycle only
        s_d.rdata = 8'h00;
        if (reg_in.rd) begin
            case (reg_in.addr)
                REG_TRIM: s_d.rdata = s_q.trim;
                REG_STATUS: begin
                    s_d.rdata[STS_READY] = (s_q.ph == PH_RUN);
                    s_d.rdata[STS_RSV] = s_q.rsv;
                    s_d.rdata[STS_SRC_LSB +: 2] = s_q.src;
                    s_d.rdata[STS_PDOWN] = (s_q.ph == PH_PDOWN);
                end
                REG_FUSES: begin
                    s_d.rdata[3:0] = s_q.fuse.src_sel;
                    s_d.rdata[FUS_STUP_LSB +: 2] = s_q.fuse.stup;
                    s_d.rdata[FUS_OPT] = s_q.fuse.opt_n;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.ph <= PH_CAPTURE;
            s_q.after_rst <= 1'b1;
            // factory default is the 1 MHz internal RC
            s_q.fuse <= '{src_sel: SEL_RESET, stup: STUP_RESET, opt_n: OPT_RESET};
            s_q.src <= SRC_IRC;
            s_q.trim <= TRIM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    delay_counter #(.W(CNT_W)) u_ck_cnt (
        .clk_in(clk_sys_in),
        .rst_in(rst_in),
        .load_in(ck_load),
        .load_val_in(ck_val),
        .step_in(1'b1),
        .done_out(ck_done)
    );

    delay_counter #(.W(CNT_W)) u_wdt_cnt (
        .clk_in(clk_sys_in),
        .rst_in(rst_in),
        .load_in(wdt_load),
        .load_val_in(wdt_val),
        .step_in(wdt_tick),
        .done_out(wdt_done)
    );

    // clock reaches the core only in the run phase
    assign core_clk_en_out = (s_q.ph == PH_RUN);
    assign pdown_out = (s_q.ph == PH_PDOWN);
    assign fuse_reserved_out = s_q.rsv;
    assign reg_rdata_out = s_q.rdata;
    // trim drives the oscillator monotonically, 00 slowest, FF fastest
    // range scaling is in the analog cell; tuning outside the four nominals is unchecked
    assign trim_value_out = s_q.trim;

    always_comb begin
        osc_ctl_out = '0;
        osc_ctl_out.lfxt_en = (s_q.src == SRC_LFXT);
        osc_ctl_out.erc_en = (s_q.src == SRC_ERC);
        osc_ctl_out.irc_en = (s_q.src == SRC_IRC);
        osc_ctl_out.erc_band = osc_ctl_out.erc_en ? 2'(s_q.fuse.src_sel - SEL_ERC_LO) : 2'h0;
        osc_ctl_out.irc_freq = osc_ctl_out.irc_en ? 2'(s_q.fuse.src_sel - SEL_IRC_LO) : 2'h0;
        // zero means the option fuse is programmed
        // both crystal pins get capacitors in crystal mode
        // only the crystal input pin gets one in external RC mode
        osc_ctl_out.cap_xin = !s_q.fuse.opt_n && (osc_ctl_out.lfxt_en || osc_ctl_out.erc_en);
        osc_ctl_out.cap_xout = !s_q.fuse.opt_n && osc_ctl_out.lfxt_en;
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    a_lfxt_select: assert property (
        osc_ctl_out.lfxt_en == (s_q.fuse.src_sel == SEL_LFXT))
        else $error("crystal enable does not follow select code");

    // covers both the boot load and the wake-up reload
    a_lfxt_long_start: assert property (
        ck_load && ((s_q.ph == PH_PDOWN && s_q.src == SRC_LFXT && s_q.fuse.stup == STUP_10)
        || (capture && new_src == SRC_LFXT && s_q.fuse_s2.stup == STUP_10))
        |-> ck_val == CNT_W'(LFXT_LONG_CK - 1))
        else $error("crystal long start-up count wrong");

    a_lfxt_caps: assert property (
        osc_ctl_out.lfxt_en && !s_q.fuse.opt_n |-> osc_ctl_out.cap_xin && osc_ctl_out.cap_xout)
        else $error("crystal capacitors missing");

    a_erc_band_map: assert property (
        osc_ctl_out.erc_en |-> osc_ctl_out.erc_band == 2'(s_q.fuse.src_sel - 4'h5))
        else $error("external RC band wrong");

    a_erc_fast_start: assert property (
        $rose(s_q.ph == PH_STARTUP) && s_q.src == SRC_ERC && s_q.fuse.stup == STUP_11
        |-> (s_q.ph == PH_STARTUP) [*6] ##1 s_q.ph != PH_STARTUP)
        else $error("external RC short start-up not six cycles");

    a_irc_start_len: assert property (
        $rose(s_q.ph == PH_STARTUP) && s_q.src == SRC_IRC
        |-> (s_q.ph == PH_STARTUP) [*6] ##1 s_q.ph != PH_STARTUP)
        else $error("internal RC start-up not six cycles");

    a_cal_load: assert property (
        capture |=> trim_value_out == $past(s_q.cal_s2))
        else $error("calibration byte not loaded");

    a_trim_source: assert property (
        $changed(trim_value_out) |-> $past(capture) || $past(trim_wr))
        else $error("trim changed without load or write");

    a_trim_write: assert property (
        trim_wr |=> trim_value_out == $past(reg_in.wdata))
        else $error("trim write not applied");

    a_erc_cap: assert property (
        osc_ctl_out.erc_en |-> osc_ctl_out.cap_xin == !s_q.fuse.opt_n && !osc_ctl_out.cap_xout)
        else $error("external RC capacitor wrong");

    a_wdt_count: assert property (
        wdt_load |-> wdt_val == CNT_W'(WDT_SHORT) || wdt_val == CNT_W'(WDT_LONG))
        else $error("reset delay count wrong");

    a_fuse_hold: assert property (
        s_q.ph != PH_CAPTURE |=> $stable(s_q.fuse))
        else $error("fuses changed while running");

    a_clock_gate: assert property (
        s_q.ph == PH_RST_DLY && !wdt_done |=> !core_clk_en_out)
        else $error("core clock released during reset delay");

    c_reset_delay: cover property (s_q.ph == PH_RST_DLY ##1 s_q.ph == PH_RUN);
    c_wake_up: cover property (s_q.ph == PH_PDOWN ##1 s_q.ph == PH_STARTUP);
    c_trim_write: cover property (trim_wr && s_q.ph == PH_RUN);
    c_lfxt_run: cover property (core_clk_en_out && osc_ctl_out.lfxt_en);
endmodule : clock_source_startup_select

/* include/clk_src_pkg.sv */
package clk_src_pkg;
    // clock source select codes, stored fuse value (1 = unprogrammed)
    localparam logic [3:0] SEL_LFXT = 4'h9;
    localparam logic [3:0] SEL_ERC_LO = 4'h5;
    localparam logic [3:0] SEL_ERC_HI = 4'h8;
    localparam logic [3:0] SEL_IRC_LO = 4'h1;
    localparam logic [3:0] SEL_IRC_HI = 4'h4;
    localparam logic [3:0] SEL_RESET = 4'h1;
    localparam logic [1:0] STUP_RESET = 2'h2;
    localparam logic OPT_RESET = 1'b1;
    localparam logic [1:0] STUP_00 = 2'h0;
    localparam logic [1:0] STUP_01 = 2'h1;
    localparam logic [1:0] STUP_10 = 2'h2;
    localparam logic [1:0] STUP_11 = 2'h3;
    // start-up counts in system clock cycles
    localparam int CNT_W = 17;
    localparam int CK_1K = 1024;
    localparam int CK_32K = 32768;
    localparam int CK_18 = 18;
    localparam int CK_6 = 6;
    // reset delays in watchdog oscillator cycles
    localparam int WDT_4K = 4096;
    localparam int WDT_64K = 65536;
    localparam int CAP_WAIT = 2;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    // register map, index on the plain register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_TRIM = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_FUSES = 4'h2;
    localparam int STS_READY = 0;
    localparam int STS_RSV = 1;
    localparam int STS_SRC_LSB = 2;
    localparam int STS_PDOWN = 4;
    localparam int FUS_STUP_LSB = 4;
    localparam int FUS_OPT = 6;
    typedef enum logic [2:0] {PH_CAPTURE, PH_STARTUP, PH_RST_DLY, PH_RUN, PH_PDOWN} phase_e;
    typedef enum logic [1:0] {SRC_OTHER, SRC_LFXT, SRC_ERC, SRC_IRC} src_e;
    typedef struct packed {
        logic [3:0] src_sel;
        logic [1:0] stup;
        logic opt_n;
    } fuse_s;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef struct packed {
        logic lfxt_en;
        logic erc_en;
        logic irc_en;
        logic [1:0] erc_band;
        logic [1:0] irc_freq;
        logic cap_xin;
        logic cap_xout;
    } osc_ctl_s;
    typedef struct packed {
        phase_e ph;
        logic [1:0] cap_cnt;
        logic after_rst;
        fuse_s fuse;
        src_e src;
        logic rsv;
        logic [7:0] trim;
        logic [7:0] rdata;
        fuse_s fuse_m;
        fuse_s fuse_s2;
        logic [7:0] cal_m;
        logic [7:0] cal_s2;
        logic [2:0] wdt_sy;
        logic [1:0] wake_sy;
    } state_s;
endpackage : clk_src_pkg

/* core/delay_counter.sv */
`timescale 1ns/1ps
module delay_counter #(
    parameter int W = 17
) (
    input wire logic clk_in, // clock
    input wire logic rst_in, // async reset, high
    input wire logic load_in, // load pulse
    input wire logic [W-1:0] load_val_in, // steps to count
    input wire logic step_in, // one step
    output logic done_out // count reached zero
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cnt_s;
    cnt_s s_q;
    cnt_s s_d;

    always_comb begin
        s_d = s_q;
        if (load_in) begin
            s_d.cnt = load_val_in;
        end else if (step_in && s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_out = (s_q.cnt == '0);
endmodule : delay_counter

/* tb/wdt_osc_model.sv */
`timescale 1ns/1ps
module wdt_osc_model #(
    parameter int HALF_NS = 300
) (
    input wire logic run_in, // oscillator powered
    output logic wdt_osc_out // watchdog oscillator waveform
);
    // free-running, unrelated to the system clock
    // each level lasts three system clocks, so the design's sync never misses an edge
    initial begin
        wdt_osc_out = 1'b0;
        forever begin
            #(HALF_NS);
            wdt_osc_out = run_in ? ~wdt_osc_out : 1'b0;
        end
    end
endmodule : wdt_osc_model

/* tb/tb_clock_source_startup_select.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_clock_source_startup_select;
    import clk_src_pkg::*;
    // shortened counts keep the run short; expectations derive from these
    localparam int LONG_CK = 40;
    localparam int WL = 20;
    localparam int WS = 10;
    localparam int WDT_P = 6;
    typedef struct {
        logic [6:0] fz;
        logic [8:0] ctl;
        int n;
        int d;
        logic rsv;
        logic [1:0] src;
    } row_s;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    fuse_s fuse_in;
    logic [7:0] calib_byte_in;
    logic wdt_osc;
    logic sleep_in;
    logic wake_in;
    reg_req_s reg_in;
    logic [7:0] reg_rdata_out;
    logic core_clk_en_out;
    osc_ctl_s osc_ctl_out;
    logic [7:0] trim_value_out;
    logic fuse_reserved_out;
    logic pdown_out;
    int miscompares = 0;
    int total_checks = 0;
    int cyc;
    int ex;
    logic [7:0] rv;
    logic in_win;
    // option fuse left unprogrammed on every internal RC row
    row_s rows[13] = '{
        '{7'h48, 9'h103, 1024, WS, 1'b0, 2'h1}, '{7'h4B, 9'h100, 1024, WL, 1'b0, 2'h1},
        '{7'h4D, 9'h100, LONG_CK, WL, 1'b0, 2'h1}, '{7'h4F, 9'h100, LONG_CK, WL, 1'b1, 2'h1},
        '{7'h28, 9'h082, 18, 0, 1'b0, 2'h2}, '{7'h33, 9'h090, 18, WS, 1'b0, 2'h2},
        '{7'h3D, 9'h0A0, 18, WL, 1'b0, 2'h2}, '{7'h47, 9'h0B0, 6, WS, 1'b0, 2'h2},
        '{7'h09, 9'h040, 6, 0, 1'b0, 2'h3}, '{7'h13, 9'h044, 6, WS, 1'b0, 2'h3},
        '{7'h1D, 9'h048, 6, WL, 1'b0, 2'h3}, '{7'h27, 9'h04C, 6, WL, 1'b1, 2'h3},
        '{7'h05, 9'h000, 6, WL, 1'b0, 2'h0}};

    always #50 clk_sys_in = ~clk_sys_in;

    wdt_osc_model u_wdt (
        .run_in(1'b1),
        .wdt_osc_out(wdt_osc)
    );

    clock_source_startup_select #(
        .LFXT_LONG_CK(LONG_CK),
        .WDT_LONG(WL),
        .WDT_SHORT(WS)
    ) u_dut (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .fuse_in(fuse_in),
        .calib_byte_in(calib_byte_in),
        .wdt_osc_in(wdt_osc),
        .sleep_in(sleep_in),
        .wake_in(wake_in),
        .reg_in(reg_in),
        .reg_rdata_out(reg_rdata_out),
        .core_clk_en_out(core_clk_en_out),
        .osc_ctl_out(osc_ctl_out),
        .trim_value_out(trim_value_out),
        .fuse_reserved_out(fuse_reserved_out),
        .pdown_out(pdown_out)
    );

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        reg_in <= '0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        reg_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        reg_in <= '0;
        #1;
        d = reg_rdata_out;
    endtask : rd

    // counts edges from reset release until the core clock is enabled
    task automatic boot(input logic [6:0] fz, output int c);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        fuse_in <= fz;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        c = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            c++;
        end while (core_clk_en_out !== 1'b1 && c < 3000);
    endtask : boot

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #5000000;
        miscompares++;
        end_sim();
    end

    initial begin
        fuse_in = 7'h0D;
        calib_byte_in = 8'hA5;
        sleep_in = 1'b0;
        wake_in = 1'b0;
        reg_in = '0;
        repeat (5) @(posedge clk_sys_in);
        #1;
        `CHK("en in reset", 1'b0, core_clk_en_out)
        `CHK("ctl in reset", 9'h040, osc_ctl_out)
        `CHK("trim in reset", 8'h00, trim_value_out)
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            boot(rows[i].fz, cyc);
            ex = 3 + rows[i].n + rows[i].d * WDT_P;
            if (rows[i].d == 0) begin
                `CHK("startup cycles", ex, cyc)
            end else begin
                in_win = cyc >= ex - WDT_P && cyc <= ex + 2 * WDT_P + 4;
                `CHK("delayed startup", 1'b1, in_win)
            end
            `CHK("osc ctl", rows[i].ctl, osc_ctl_out)
            `CHK("reserved", rows[i].rsv, fuse_reserved_out)
            `CHK("trim loaded", 8'hA5, trim_value_out)
            rd(REG_STATUS, rv);
            `CHK("status", {3'b000, 1'b0, rows[i].src, rows[i].rsv, 1'b1}, rv)
            rd(REG_FUSES, rv);
            // register holds select code low, start-up code above, option bit on top
            `CHK("fuses", {1'b0, rows[i].fz[0], rows[i].fz[2:1], rows[i].fz[6:3]}, rv)
        end
        boot(7'h09, cyc);
        // no memory write runs here, so high trims are safe
        foreach (rows[i]) begin
            if (i < 4) begin
                wr(REG_TRIM, 8'h00 + 8'h7F * i[7:0]);
                `CHK("trim out", 8'h00 + 8'h7F * i[7:0], trim_value_out)
                rd(REG_TRIM, rv);
                `CHK("trim read", 8'h00 + 8'h7F * i[7:0], rv)
            end
        end
        @(posedge clk_sys_in);
        #1;
        `CHK("rdata released", 8'h00, reg_rdata_out)
        wr(REG_STATUS, 8'hFF);
        rd(REG_STATUS, rv);
        `CHK("status read-only", 8'h0D, rv)
        rd(4'h5, rv);
        `CHK("unmapped read", 8'h00, rv)
        @(posedge clk_sys_in);
        fuse_in <= 7'h48;
        repeat (4) @(posedge clk_sys_in);
        #1;
        `CHK("fuse held", 9'h040, osc_ctl_out)
        rd(REG_FUSES, rv);
        `CHK("fuse reg held", 8'h41, rv)
        @(posedge clk_sys_in);
        sleep_in <= 1'b1;
        @(posedge clk_sys_in);
        sleep_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        `CHK("gated in sleep", 1'b0, core_clk_en_out)
        `CHK("power-down", 1'b1, pdown_out)
        @(posedge clk_sys_in);
        wake_in <= 1'b1;
        cyc = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            cyc++;
        end while (core_clk_en_out !== 1'b1 && cyc < 100);
        wake_in <= 1'b0;
        `CHK("wake cycles", 3 + 6, cyc)
        `CHK("trim kept on wake", 8'h7D, trim_value_out)
        calib_byte_in <= 8'h3C;
        boot(7'h09, cyc);
        `CHK("reboot trim", 8'h3C, trim_value_out)
        `CHK("reboot ctl", 9'h040, osc_ctl_out)
        end_sim();
    end
endmodule : tb_clock_source_startup_select
